// ### src/port_m_pad_config_and_routing.sv
// Notes on behaviour
// - Set bit gives one-fifth drive strength
// - Drive setting ignored on input pins
// - Pull enable bit activates input pull
// - Output pull only in open-drain mode
// - Polarity one pull-down, zero pull-up
// - CAN active blocks receive pin pull-down
// - Open-drain drives low, releases high
// - Open-drain any owner, not inputs
// - Bits 7:6 place serial unit pins
// - Bit 4 places SPI on S or M
// - Reserved serial code acts as reset
// - Five control registers read and write anytime, status read-only
// - Pull enable clears on reset
// - Routed unit overrides general purpose pin
`timescale 1ns/10ps
`default_nettype none

module port_m_pad_config_and_routing
  import port_m_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  // Pin direction, one is output
  input  wire logic [7:0]  PIN_IS_OUTPUT,
  // Unit enables
  input  wire logic        CAN_ACTIVE,
  input  wire logic        SCI_ENABLE,
  input  wire logic        SPI_ENABLE,
  // Pad controls to port M
  output pad_ctrl_t        PAD_CTRL,
  // Unit placement
  output route_t           MODULE_ROUTE,
  // Pins taken from general use
  output logic      [7:0]  PERIPH_OWNED
);

  // Software registers
  logic [7:0]  reduced_drive_select_reg; // Drive per pin
  logic [7:0]  pull_enable_reg;          // Pull enable
  logic [7:0]  pull_polarity_select_reg; // Pull direction
  logic [7:0]  open_drain_select_reg;    // Wired-or mode
  logic [7:0]  module_route_select_reg;  // Placement

  // Bus data-phase state
  logic        wr_pend_reg;  // Write in data phase
  logic        rd_pend_reg;  // Read in data phase
  logic [11:0] addr_reg;     // Latched address
  logic [1:0]  wait_reg;     // Read wait count
  logic [31:0] rdata_reg;    // Read data
  logic        addr_ok;      // Address phase taken
  logic        wr_hit;       // Write completes now

  // Effective placement and ownership
  logic [1:0]  sci_place;    // Decoded serial field
  logic        spi_on_m;     // SPI on port M
  logic [7:0]  owned;        // Unit-owned pins
  logic [7:0]  status_byte;  // Read-only status
  logic [7:0]  wdata;        // Low byte of write data
  logic [7:0]  rd_byte;      // Register picked for a read

  // Per-register write strobes
  logic        we_rdrv;      // Drive register
  logic        we_pulle;     // Pull enable register
  logic        we_polar;     // Polarity register
  logic        we_odrn;      // Open-drain register
  logic        we_route;     // Route register

  // Pad control vectors, one bit per pin
  wire logic [7:0] drv_w;    // Reduced drive
  wire logic [7:0] pull_w;   // Pull device on
  wire logic [7:0] down_w;   // Pull-down chosen
  wire logic [7:0] odrn_w;   // Wired-or output

  // Decode a word address to a register select
  function automatic logic sel(
    input logic [11:0] a,
    input logic [11:0] base
  );
    // Whole word offset must match
    sel = (a == base);
  endfunction : sel

  // Read multiplexer
  function automatic logic [7:0] rd_mux(
    input logic [11:0] a,
    input logic [7:0]  rdv,
    input logic [7:0]  pe,
    input logic [7:0]  pol,
    input logic [7:0]  od,
    input logic [7:0]  rt,
    input logic [7:0]  st
  );
    rd_mux = 8'h00;
    // Unmapped reads zero
    if (sel(a, RDRV_ADDR)) begin
      // Drive strength bits
      rd_mux = rdv;
    end else if (sel(a, PULLE_ADDR)) begin
      // Pull enable bits
      rd_mux = pe;
    end else if (sel(a, POLAR_ADDR)) begin
      // Pull direction bits
      rd_mux = pol;
    end else if (sel(a, ODRN_ADDR)) begin
      // Wired-or bits
      rd_mux = od;
    end else if (sel(a, ROUTE_ADDR)) begin
      // Stored placement bits
      rd_mux = rt;
    end else if (sel(a, STAT_ADDR)) begin
      // Live placement and SPI pin ownership
      rd_mux = st;
    end
  endfunction : rd_mux

  // Address phase accepted by this slave
  assign addr_ok = HSEL & HREADY & HTRANS[1];

  // Write takes effect at end of data phase
  assign wr_hit = wr_pend_reg;

  // Write data low byte, upper bits ignored
  assign wdata = HWDATA[7:0];

  // One strobe per register, in the write data phase
  assign we_rdrv  = wr_hit & sel(addr_reg, RDRV_ADDR);
  assign we_pulle = wr_hit & sel(addr_reg, PULLE_ADDR);
  assign we_polar = wr_hit & sel(addr_reg, POLAR_ADDR);
  assign we_odrn  = wr_hit & sel(addr_reg, ODRN_ADDR);
  assign we_route = wr_hit & sel(addr_reg, ROUTE_ADDR);

  // Latch address phase
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // No transfer pending
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 12'h000;
    end else if (HREADYOUT) begin
      // New phase only when bus moves on
      wr_pend_reg <= addr_ok & HWRITE;
      rd_pend_reg <= addr_ok & ~HWRITE;
      if (addr_ok) begin
        // Word address of the new transfer
        addr_reg <= {HADDR[11:2], 2'h0};
      end
    end
  end

  // Read wait counter, one stall cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // No stall after reset
      wait_reg <= 2'h0;
    end else if (HREADYOUT && addr_ok && !HWRITE) begin
      // Read starts its wait
      wait_reg <= RD_WAIT;
    end else if (wait_reg != 2'h0) begin
      // Count the stall down
      wait_reg <= wait_reg - 2'h1;
    end
  end

  // Ready low while a read waits
  assign HREADYOUT = (wait_reg == 2'h0);

  // Always OKAY
  assign HRESP = 1'b0;

  // Read data from flip-flops
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Empty read data after reset
      rdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg && !HREADYOUT) begin
      // Capture once prior writes are done
      rdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // Register byte picked by the data-phase address
  assign rd_byte = rd_mux(addr_reg,
                          reduced_drive_select_reg,
                          pull_enable_reg,
                          pull_polarity_select_reg,
                          open_drain_select_reg,
                          module_route_select_reg,
                          status_byte);

  // Upper read bits stay zero
  assign HRDATA = rdata_reg;

  // Drive strength register
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Full drive on every pin
      reduced_drive_select_reg <= RDRV_RST;
    end else if (we_rdrv) begin
      // Software write, any time
      reduced_drive_select_reg <= wdata;
    end
  end

  // Pull enable register
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Every pull device off
      pull_enable_reg <= PULLE_RST;
    end else if (we_pulle) begin
      // Software write, any time
      pull_enable_reg <= wdata;
    end
  end

  // Pull polarity register
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Pull-up direction on every pin
      pull_polarity_select_reg <= POLAR_RST;
    end else if (we_polar) begin
      // Software write, any time
      pull_polarity_select_reg <= wdata;
    end
  end

  // Open-drain register
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Push-pull outputs
      open_drain_select_reg <= ODRN_RST;
    end else if (we_odrn) begin
      // Software write, any time
      open_drain_select_reg <= wdata;
    end
  end

  // Route register, unused bits held zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      // Default serial and SPI placement
      module_route_select_reg <= ROUTE_RST;
    end else if (we_route) begin
      // Software write, only routing bits kept
      module_route_select_reg <= wdata & ROUTE_MASK;
    end
  end

  // Serial placement, reserved code maps to reset
  always_comb begin
    // Stored field first
    sci_place = module_route_select_reg[SCI_LSB +: 2];
    if (sci_place == SCI_RSVD) begin
      // Reserved acts as reset placement
      sci_place = ROUTE_RST[SCI_LSB +: 2];
    end
  end

  // SPI placement
  assign spi_on_m = module_route_select_reg[SPI_BIT];

  // Placement bundle to the units
  assign MODULE_ROUTE = '{sci_place: sci_place,
                          spi_on_m:  spi_on_m};

  // Pins owned by an enabled unit
  always_comb begin
    owned = 8'h00;
    // SPI on M2..M5
    if (SPI_ENABLE && spi_on_m) begin
      owned = owned | SPI_M_MASK;
    end
    // Serial unit on M0, M1
    if (SCI_ENABLE && sci_place == SCI_ON_M) begin
      owned = owned | SCI_M_MASK;
    end
    // CAN always on M0, M1
    if (CAN_ACTIVE) begin
      owned = owned | SCI_M_MASK;
    end
  end

  // Pins handed to the units
  assign PERIPH_OWNED = owned;

  // Status: placement and SPI-owned pins
  always_comb begin
    status_byte      = 8'h00;       // Bit 5 reads zero
    status_byte[7:6] = sci_place;   // Effective serial placement
    status_byte[4]   = spi_on_m;    // SPI on port M
    status_byte[3:0] = owned[5:2];  // Pins held by the SPI
  end

  // Per-pin pad control
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic out_w;  // Pin drives
      logic pe_w;   // Pull active
      logic blk_w;  // Pull-down blocked
      // Effective direction of this pin
      assign out_w = PIN_IS_OUTPUT[g];
      // Drive only matters for outputs
      assign drv_w[g] =
        reduced_drive_select_reg[g] & out_w;
      // Wired-or mode only on outputs
      assign odrn_w[g] =
        open_drain_select_reg[g] & out_w;
      // Pull on inputs, or wired-or outputs
      assign pe_w = pull_enable_reg[g] &
        (~out_w | open_drain_select_reg[g]);
      // Pull enable to the pad
      assign pull_w[g] = pe_w;
      // CAN receive pin refuses pull-down
      assign blk_w = CAN_ACTIVE & CAN_RX_MASK[g];
      // Polarity one picks pull-down, else pull-up
      assign down_w[g] =
        pe_w & pull_polarity_select_reg[g] & ~blk_w;
    end
  endgenerate

  // Gather the pin vectors into the pad bundle
  assign PAD_CTRL = '{reduced_drive: drv_w,
                      pull_enable:   pull_w,
                      pull_down:     down_w,
                      open_drain:    odrn_w};

endmodule : port_m_pad_config_and_routing

`default_nettype wire

// ### include/port_m_pkg.sv
`default_nettype none

package port_m_pkg;

  // Register byte addresses
  localparam logic [11:0] RDRV_ADDR  = 12'h0250;
  localparam logic [11:0] PULLE_ADDR = 12'h0254;
  localparam logic [11:0] POLAR_ADDR = 12'h0258;
  localparam logic [11:0] ODRN_ADDR  = 12'h025C;
  localparam logic [11:0] ROUTE_ADDR = 12'h0260;
  localparam logic [11:0] STAT_ADDR  = 12'h0264;

  // Values after reset
  localparam logic [7:0] RDRV_RST  = 8'h00;
  localparam logic [7:0] PULLE_RST = 8'h00;
  localparam logic [7:0] POLAR_RST = 8'h00;
  localparam logic [7:0] ODRN_RST  = 8'h00;
  localparam logic [7:0] ROUTE_RST = 8'h00;

  // Route register field positions
  localparam int SCI_LSB = 6;
  localparam int SPI_BIT = 4;
  // Writable route bits, others read zero
  localparam logic [7:0] ROUTE_MASK = 8'hD0;

  // Serial unit placements
  localparam logic [1:0] SCI_ON_S = 2'h0;
  localparam logic [1:0] SCI_ON_P = 2'h1;
  localparam logic [1:0] SCI_ON_M = 2'h2;
  localparam logic [1:0] SCI_RSVD = 2'h3;

  // Port M pins in use by routed units
  localparam logic [7:0] CAN_RX_MASK = 8'h01;
  localparam logic [7:0] SCI_M_MASK  = 8'h03;
  localparam logic [7:0] SPI_M_MASK  = 8'h3C;

  // Read wait states on the bus
  localparam logic [1:0] RD_WAIT = 2'h1;

  // Pad controls, one bit per pin each
  typedef struct packed {
    logic [7:0] reduced_drive;
    logic [7:0] pull_enable;
    logic [7:0] pull_down;
    logic [7:0] open_drain;
  } pad_ctrl_t;

  // Effective unit placement
  typedef struct packed {
    logic [1:0] sci_place;
    logic       spi_on_m;
  } route_t;

endpackage : port_m_pkg

`default_nettype wire

// ### bench/port_m_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module port_m_monitor
  import port_m_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RESET_N,
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  input wire logic [7:0] PIN_IS_OUTPUT,
  input wire logic       CAN_ACTIVE,
  input wire logic       SPI_ENABLE,
  input wire pad_ctrl_t  PAD_CTRL,
  input wire route_t     MODULE_ROUTE,
  input wire logic [7:0] PERIPH_OWNED
);
  // One clock, one reset
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Transfer taken at this edge
  wire logic go = HSEL && HREADY && HTRANS[1] && HREADYOUT;
  wire logic [7:0] po = PIN_IS_OUTPUT;
  rst_clear_a: assert property (disable iff (1'b0)
    !RESET_N |=> PAD_CTRL == 32'h0000_0000 && MODULE_ROUTE == 3'h0) else $error("not cleared");
  bus_okay_a: assert property (HRESP == 1'b0) else $error("bad response");
  rd_wait_a: assert property (go && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait wrong");
  wr_wait_a: assert property (go && HWRITE |=> HREADYOUT) else $error("write wait");
  drive_in_a: assert property ((PAD_CTRL.reduced_drive & ~po) == 8'h00)
    else $error("drive on input");
  od_in_a: assert property ((PAD_CTRL.open_drain & ~po) == 8'h00)
    else $error("open drain on input");
  pull_out_a: assert property ((PAD_CTRL.pull_enable & po & ~PAD_CTRL.open_drain) == 8'h00)
    else $error("pull on push-pull");
  pdown_en_a: assert property ((PAD_CTRL.pull_down & ~PAD_CTRL.pull_enable) == 8'h00)
    else $error("pull-down without pull");
  can_pull_a: assert property (CAN_ACTIVE |-> !PAD_CTRL.pull_down[0])
    else $error("pull-down on can pin");
  sci_rsvd_a: assert property (MODULE_ROUTE.sci_place != SCI_RSVD)
    else $error("reserved placement");
  spi_own_a: assert property (PERIPH_OWNED[5:2] == {4{SPI_ENABLE & MODULE_ROUTE.spi_on_m}})
    else $error("spi ownership wrong");
  // Main scenarios
  rd_c: cover property (go && !HWRITE);
  can_c: cover property (CAN_ACTIVE && PAD_CTRL.pull_enable[0]);
  spi_c: cover property (PERIPH_OWNED[5:2] == 4'hF);
endmodule : port_m_monitor
`default_nettype wire

// ### bench/test_port_m_pad_config_and_routing.sv
`timescale 1ns/10ps
`default_nettype none
module test_port_m_pad_config_and_routing;
  import port_m_pkg::*;
  logic        clk = 1'b0;    // Bus clock
  logic        rst_n;         // Reset, low active
  logic        hsel;          // Bus select
  logic [31:0] haddr;         // Bus address
  logic [1:0]  htrans;        // Transfer type
  logic        hwrite;        // Write flag
  logic [31:0] hwdata;        // Write data
  wire  logic  hreadyout;     // Slave ready
  wire  logic [31:0] hrdata;  // Read data
  logic [7:0]  out;           // Pin directions
  logic        can, sci, spi; // Unit enables
  pad_ctrl_t   pad;           // Pad controls seen
  route_t      rte;           // Placement seen
  logic [7:0]  own;           // Owned pins seen
  logic [31:0] v, r;          // Pad bytes, read value
  logic [7:0]  rt;            // Route byte
  logic [1:0]  sp;            // Expected placement
  int          n_mismatch = 0, compares = 0, i, a;
  // Clock of 100 MHz
  always #5 clk = ~clk;
  port_m_pad_config_and_routing u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout),
    .HWDATA(hwdata), .HREADYOUT(hreadyout), .HRESP(), .HRDATA(hrdata),
    .PIN_IS_OUTPUT(out), .CAN_ACTIVE(can), .SCI_ENABLE(sci), .SPI_ENABLE(spi),
    .PAD_CTRL(pad), .MODULE_ROUTE(rte), .PERIPH_OWNED(own));
  // Verdict and end of run
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One single bus transfer
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [7:0] d,
                      output logic [31:0] rd);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0_0000, ad};
    do @(posedge clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h00_0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // Expected pad controls
  function automatic pad_ctrl_t pad_exp(input logic [31:0] x, input logic [7:0] o,
                                        input logic c);
    pad_ctrl_t p;
    p.reduced_drive = x[31:24] & o;
    p.open_drain    = x[7:0] & o;
    p.pull_enable   = x[23:16] & (~o | x[7:0]);
    p.pull_down     = p.pull_enable & x[15:8] & ~{7'h00, c};
    return p;
  endfunction : pad_exp
  // Hang guard
  initial begin
    #100_000;
    n_mismatch++;
    conclude();
  end
  // Main sequence
  initial begin
    {rst_n, hsel, htrans, hwrite, haddr, hwdata} <= '0;
    {out, can, sci, spi} <= '0;
    r = $urandom(79568);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (a = 0; a < 5; a++) begin
      xfer(1'b0, RDRV_ADDR + 12'(a * 4), 8'h00, r);
      chk("reset value", r, 32'h0000_0000);
    end
    for (i = 0; i < 24; i++) begin
      v = $urandom;
      rt = {2'(i), 6'($urandom)};
      out <= 8'($urandom);
      {can, sci, spi} <= 3'($urandom);
      for (a = 0; a < 4; a++) xfer(1'b1, RDRV_ADDR + 12'(a * 4), v[31 - 8 * a -: 8], r);
      xfer(1'b1, ROUTE_ADDR, rt, r);
      #1;
      sp = (rt[7:6] == SCI_RSVD) ? SCI_ON_S : rt[7:6];
      chk("pad controls", pad, pad_exp(v, out, can));
      chk("placement", 32'(rte), 32'({sp, rt[4]}));
      chk("owned pins", 32'(own), {26'h0, {4{spi & rt[4]}}, {2{(sci && sp == SCI_ON_M) || can}}});
      for (a = 0; a < 5; a++) begin
        xfer(1'b0, RDRV_ADDR + 12'(a * 4), 8'h00, r);
        chk("readback", r, {24'h00_0000, (a < 4) ? v[31 - 8 * a -: 8] : rt & ROUTE_MASK});
      end
      xfer(1'b0, STAT_ADDR, 8'h00, r);
      chk("status", r, {24'h00_0000, sp, 1'h0, rt[4], {4{spi & rt[4]}}});
    end
    // CAN active: receive pin keeps only its pull-up
    out <= 8'h00;
    can <= 1'b1;
    v = 32'h0001_0100;
    for (a = 0; a < 4; a++) xfer(1'b1, RDRV_ADDR + 12'(a * 4), v[31 - 8 * a -: 8], r);
    #1;
    chk("can pin pull", pad, 32'h0001_0000);
    xfer(1'b1, STAT_ADDR, 8'hFF, r);
    xfer(1'b0, STAT_ADDR, 8'h00, r);
    chk("status kept", r, {24'h00_0000, sp, 1'h0, rt[4], {4{spi & rt[4]}}});
    xfer(1'b1, 12'h26C, 8'hFF, r);
    xfer(1'b0, 12'h26C, 8'h00, r);
    chk("unmapped read", r, 32'h0000_0000);
    conclude();
  end
endmodule : test_port_m_pad_config_and_routing
bind port_m_pad_config_and_routing port_m_monitor u_mon (.CORE_CLK, .RESET_N, .HSEL,
  .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .PIN_IS_OUTPUT, .CAN_ACTIVE,
  .SPI_ENABLE, .PAD_CTRL, .MODULE_ROUTE, .PERIPH_OWNED);
`default_nettype wire
